/* File: dv/mac_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mac_consts.svh"
module mac_mem_model (
    // clock
    input wire logic clk,
    // load and store strobes from the sequencer side
    input wire logic mem_ld,
    input wire logic mem_st,
    input wire logic [3:0] addr,
    // data memory data bus halves
    input wire logic [`MAC_DATA_W-1:0] st_data,
    output logic [`MAC_DATA_W-1:0] ld_data
);
    logic [`MAC_DATA_W-1:0] mem [16];
    logic [`MAC_DATA_W-1:0] last = 16'h0000;
    // a released bus shows the inverse of the last word, so stale data
    // can never pass for a fresh load
    assign ld_data = mem_ld ? mem[addr] : ~last;
    // stores take the word read at the start of the cycle, at its end
    always @(posedge clk) begin
        if (mem_st) begin
            mem[addr] <= st_data;
        end
        if (mem_ld) begin
            last <= mem[addr];
        end
    end
endmodule
`default_nettype wire

/* File: dv/mac_unit_checker.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mac_consts.svh"
module mac_unit_checker
    import mac_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // instruction side
    input wire logic [`MAC_MODE_W-1:0] mode_status_register,
    input wire logic op_valid,
    input wire mac_op_t op_code,
    // bus side
    input wire logic dmd_wr_en,
    input wire mac_reg_t dmd_wr_sel,
    input wire logic [`MAC_DATA_W-1:0] dmd_wr_data,
    input wire mac_reg_t dmd_rd_sel,
    input wire logic [`MAC_DATA_W-1:0] dmd_rd_data,
    input wire logic pmd_wr_en,
    input wire logic pmd_wr_sel,
    input wire logic [`MAC_DATA_W-1:0] pmd_wr_data,
    input wire mac_reg_t rbus_rd_sel,
    input wire logic [`MAC_DATA_W-1:0] rbus_rd_data,
    // status outputs
    input wire logic multiply_overflow_flag,
    input wire logic multiply_overflow_wr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // single-cycle sequences used by the load checks
    sequence s_file_load;
        dmd_wr_en && dmd_wr_sel inside {mac_reg_x0, mac_reg_x1,
            mac_reg_y0, mac_reg_y1};
    endsequence
    sequence s_mid_load;
        dmd_wr_en && dmd_wr_sel == mac_reg_acc_mid && !op_valid;
    endsequence
    sequence s_same_bank;
        $stable(mode_status_register[`MAC_MODE_BANK_BIT]);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    AST_FILE_LOAD: assert property (
        s_file_load ##1 (dmd_rd_sel == $past(dmd_wr_sel)) ##0 s_same_bank
        |-> dmd_rd_data == $past(dmd_wr_data))
        else $error("operand file load not visible next cycle");
    AST_MID_FILL: assert property (
        s_mid_load ##1 (dmd_rd_sel == mac_reg_acc_ext) ##0 s_same_bank
        |-> dmd_rd_data == {16{$past(dmd_wr_data[15])}})
        else $error("middle load did not fill extension");
    AST_PMD_Y: assert property (
        pmd_wr_en && !dmd_wr_en ##1 (dmd_rd_sel ==
        ($past(pmd_wr_sel) ? mac_reg_y1 : mac_reg_y0)) ##0 s_same_bank
        |-> dmd_rd_data == $past(pmd_wr_data))
        else $error("program bus write to y file lost");
    AST_HOLD: assert property (
        !dmd_wr_en && !pmd_wr_en && !op_valid ##1 $stable(dmd_rd_sel)
        && $stable(mode_status_register) |-> $stable(dmd_rd_data))
        else $error("register changed without a write");
    AST_EXT_DMD: assert property (
        dmd_rd_sel == mac_reg_acc_ext
        |-> dmd_rd_data[15:8] == {8{dmd_rd_data[7]}})
        else $error("extension not sign extended on data bus");
    AST_EXT_RBUS: assert property (
        rbus_rd_sel == mac_reg_acc_ext
        |-> rbus_rd_data[15:8] == {8{rbus_rd_data[7]}})
        else $error("extension not sign extended on result bus");
    AST_RBUS_ONLY: assert property (
        !(rbus_rd_sel inside {mac_reg_acc_low, mac_reg_acc_mid,
        mac_reg_acc_ext}) |-> rbus_rd_data == 16'h0000)
        else $error("result bus driven by a non accumulator register");
    AST_WR_PULSE: assert property (
        1'b1 |=> multiply_overflow_wr == $past(op_valid))
        else $error("overflow write pulse not tied to operation");
    AST_FLAG_HOLD: assert property (
        !op_valid |=> $stable(multiply_overflow_flag))
        else $error("overflow flag moved without an operation");
    AST_CLEAR: assert property (
        op_valid && op_code == mac_op_clear |=> !multiply_overflow_flag)
        else $error("clear left overflow set");
endmodule
`default_nettype wire
bind mac_unit mac_unit_checker i_chk (
    .clk(clk), .rst_n(rst_n), .mode_status_register(mode_status_register),
    .op_valid(op_valid), .op_code(op_code), .dmd_wr_en(dmd_wr_en),
    .dmd_wr_sel(dmd_wr_sel), .dmd_wr_data(dmd_wr_data),
    .dmd_rd_sel(dmd_rd_sel), .dmd_rd_data(dmd_rd_data),
    .pmd_wr_en(pmd_wr_en), .pmd_wr_sel(pmd_wr_sel),
    .pmd_wr_data(pmd_wr_data), .rbus_rd_sel(rbus_rd_sel),
    .rbus_rd_data(rbus_rd_data),
    .multiply_overflow_flag(multiply_overflow_flag),
    .multiply_overflow_wr(multiply_overflow_wr)
);

/* File: dv/mac_unit_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mac_consts.svh"
module mac_unit_tb
    import mac_pkg::*;
;
    logic clk, rst_n, op_valid, xs, ys, to_fb, dwe, pwe, pws, flag, wr;
    logic mem_ld, mem_st;
    logic [3:0] addr;
    logic [15:0] mode, alu, pwd, drd, rbd, ldd;
    mac_op_t op_code;
    mac_xsrc_t xsrc;
    mac_ysrc_t ysrc;
    mac_reg_t dws, drs, rbs;
    int err_total = 0;
    int cmp_count = 0;
    mac_unit i_dut (.clk(clk), .rst_n(rst_n), .mode_status_register(mode),
        .op_valid(op_valid), .op_code(op_code), .op_x_signed(xs),
        .op_y_signed(ys), .op_x_src(xsrc), .op_y_src(ysrc),
        .op_to_feedback(to_fb), .alu_result_register(alu),
        .dmd_wr_en(dwe), .dmd_wr_sel(dws), .dmd_wr_data(ldd),
        .dmd_rd_sel(drs), .dmd_rd_data(drd), .pmd_wr_en(pwe),
        .pmd_wr_sel(pws), .pmd_wr_data(pwd), .rbus_rd_sel(rbs),
        .rbus_rd_data(rbd), .multiply_overflow_flag(flag),
        .multiply_overflow_wr(wr));
    mac_mem_model i_mem (.clk(clk), .mem_ld(mem_ld), .mem_st(mem_st),
        .addr(addr), .st_data(drd), .ld_data(ldd));
    ////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [39:0] e, got);
        cmp_count++;
        if (got !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
        end
    endtask
    // expected accumulator word after a plain multiply
    function automatic logic [39:0] prod(input logic [15:0] x, y,
        input logic sx, sy, im);
        logic signed [33:0] a, b, m;
        logic [39:0] v;
        a = sx ? {{18{x[15]}}, x} : {18'h0_0000, x};
        b = sy ? {{18{y[15]}}, y} : {18'h0_0000, y};
        m = a * b;
        v = {{8{m[31] & (sx | sy)}}, m[31:0]};
        return im ? v : {v[38:0], 1'b0};
    endfunction
    task automatic ld(input mac_reg_t sel, input logic [15:0] v);
        @(negedge clk);
        i_mem.mem[0] = v;
        addr = 4'h0;
        mem_ld = 1'b1;
        dwe = 1'b1;
        dws = sel;
        drs = (sel == mac_reg_acc_mid) ? mac_reg_acc_ext : sel;
        @(negedge clk);
        mem_ld = 1'b0;
        dwe = 1'b0;
    endtask
    // read once on the bus at once, then again through a memory store
    task automatic rd(input mac_reg_t sel, input logic [15:0] e);
        @(negedge clk);
        drs = sel;
        addr = 4'h1;
        mem_st = 1'b1;
        #1 chk("data bus read", e, drd);
        @(negedge clk);
        mem_st = 1'b0;
        chk("stored word", e, i_mem.mem[1]);
    endtask
    task automatic acc(input logic [39:0] e);
        rd(mac_reg_acc_low, e[15:0]);
        rd(mac_reg_acc_mid, e[31:16]);
        rd(mac_reg_acc_ext, {{8{e[39]}}, e[39:32]});
    endtask
    task automatic op(input mac_op_t c, input logic sx, sy,
        input mac_xsrc_t xr, input mac_ysrc_t yr, input logic fb);
        @(negedge clk);
        op_valid = 1'b1;
        op_code = c;
        xs = sx;
        ys = sy;
        xsrc = xr;
        ysrc = yr;
        to_fb = fb;
        @(negedge clk);
        op_valid = 1'b0;
        chk("overflow write", 1'b1, wr);
    endtask
    task automatic op0(input mac_op_t c);
        op(c, 1'b0, 1'b0, mac_xsrc_x0, mac_ysrc_y0, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        for (int i = 0; i < 8; i++) begin
            rd(mac_reg_t'(i[2:0]), 16'h0000);
        end
        chk("flag after reset", 1'b0, flag);
    endtask
    task automatic t_sections;
        ld(mac_reg_acc_mid, 16'h8000);
        rd(mac_reg_acc_ext, 16'hffff);
        ld(mac_reg_acc_ext, 16'h0012);
        ld(mac_reg_acc_low, 16'h1234);
        acc(40'h12_8000_1234);
        ld(mac_reg_acc_ext, 16'h0080);
        rbs = mac_reg_acc_ext;
        #1 chk("result bus ext", 16'hff80, rbd);
        rbs = mac_reg_acc_mid;
        #1 chk("result bus mid", 16'h8000, rbd);
    endtask
    task automatic t_formats;
        logic [2:0] k;
        ld(mac_reg_x0, 16'h8001);
        ld(mac_reg_y0, 16'hfffe);
        for (int i = 0; i < 8; i++) begin
            k = i[2:0];
            mode[`MAC_MODE_INT_BIT] = k[2];
            op(mac_op_mult, k[1], k[0], mac_xsrc_x0, mac_ysrc_y0,
                1'b0);
            acc(prod(16'h8001, 16'hfffe, k[1], k[0], k[2]));
        end
    endtask
    task automatic t_accum;
        ld(mac_reg_x0, 16'h0003);
        ld(mac_reg_y0, 16'h0005);
        op0(mac_op_mult);
        op0(mac_op_add);
        acc(40'h00_0000_001e);
        op0(mac_op_sub);
        acc(40'h00_0000_000f);
        op0(mac_op_clear);
        acc(40'h00_0000_0000);
        ld(mac_reg_acc_mid, 16'h7fff);
        ld(mac_reg_acc_low, 16'hffff);
        op0(mac_op_add);
        chk("overflow set", 1'b1, flag);
        acc(40'h00_8000_000e);
        op0(mac_op_sub);
        chk("overflow gone", 1'b0, flag);
    endtask
    task automatic t_feedback;
        ld(mac_reg_x0, 16'h1234);
        ld(mac_reg_y0, 16'h0100);
        op(mac_op_mult, 1'b0, 1'b0, mac_xsrc_x0, mac_ysrc_y0, 1'b1);
        rd(mac_reg_feedback, 16'h0012);
        rd(mac_reg_acc_low, 16'hffff);
        op(mac_op_mult, 1'b0, 1'b0, mac_xsrc_x0, mac_ysrc_feedback,
            1'b0);
        acc(40'h00_0001_47a8);
    endtask
    task automatic t_xsrc;
        alu = 16'h0003;
        ld(mac_reg_y0, 16'h0002);
        op(mac_op_mult, 1'b0, 1'b0, mac_xsrc_alu, mac_ysrc_y0, 1'b0);
        rd(mac_reg_acc_low, 16'h0006);
        op(mac_op_mult, 1'b0, 1'b0, mac_xsrc_acc_low, mac_ysrc_y0, 1'b0);
        rd(mac_reg_acc_low, 16'h000c);
        ld(mac_reg_acc_mid, 16'h0005);
        op(mac_op_mult, 1'b0, 1'b0, mac_xsrc_acc_mid, mac_ysrc_y0, 1'b0);
        rd(mac_reg_acc_low, 16'h000a);
        ld(mac_reg_acc_ext, 16'h0080);
        op(mac_op_mult, 1'b0, 1'b0, mac_xsrc_acc_ext, mac_ysrc_y0, 1'b0);
        acc(40'h00_0001_ff00);
    endtask
    task automatic t_bank;
        ld(mac_reg_x1, 16'h00aa);
        mode[`MAC_MODE_BANK_BIT] = 1'b1;
        rd(mac_reg_x1, 16'h0000);
        @(negedge clk);
        pwe = 1'b1;
        pws = 1'b1;
        pwd = 16'h2222;
        drs = mac_reg_y1;
        @(negedge clk);
        pwe = 1'b0;
        rd(mac_reg_y1, 16'h2222);
        mode[`MAC_MODE_BANK_BIT] = 1'b0;
        rd(mac_reg_y1, 16'h0000);
        // operand reload in the same cycle that it feeds the multiplier
        @(negedge clk);
        i_mem.mem[0] = 16'h0005;
        addr = 4'h0;
        mem_ld = 1'b1;
        dwe = 1'b1;
        dws = mac_reg_x0;
        drs = mac_reg_x1;
        op_valid = 1'b1;
        op_code = mac_op_mult;
        xsrc = mac_xsrc_x0;
        #1 chk("dual port read", 16'h00aa, drd);
        @(negedge clk);
        mem_ld = 1'b0;
        dwe = 1'b0;
        op_valid = 1'b0;
        rd(mac_reg_acc_low, 16'h2468);
        rd(mac_reg_x0, 16'h0005);
        op(mac_op_add, 1'b0, 1'b0, mac_xsrc_x1, mac_ysrc_y0, 1'b0);
        rd(mac_reg_acc_low, 16'h25bc);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // watchdog, several times the expected run length
    initial begin
        #(40 * 4000);
        err_total++;
        conclude();
    end
    // main sequence
    initial begin
        {rst_n, op_valid, xs, ys, to_fb, dwe, pwe, pws} = 8'h00;
        {mem_ld, mem_st, addr} = 6'h00;
        {mode, alu, pwd} = 48'h0000_0000_0000;
        op_code = mac_op_mult;
        xsrc = mac_xsrc_x0;
        ysrc = mac_ysrc_y0;
        dws = mac_reg_x0;
        drs = mac_reg_x0;
        rbs = mac_reg_x0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_sections();
        t_formats();
        t_accum();
        t_feedback();
        t_xsrc();
        t_bank();
        conclude();
    end
endmodule
`default_nettype wire

/* File: rtl/mac_consts.svh */
`ifndef MAC_CONSTS_SVH
`define MAC_CONSTS_SVH
`define MAC_DATA_W 16
`define MAC_PROD_W 32
`define MAC_ACC_W 40
`define MAC_EXT_W 8
`define MAC_BANKS 2
`define MAC_MODE_W 16
`define MAC_MODE_BANK_BIT 0
`define MAC_MODE_INT_BIT 4
`define MAC_FB_LSB 16
`define MAC_FB_MSB 31
`define MAC_MV_LSB 31
`define MAC_MV_MSB 39
`define MAC_REG_RST 16'h0000
`define MAC_EXT_RST 8'h00
`define MAC_ACC_RST 40'h00_0000_0000
`endif

/* File: rtl/mac_multiplier.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mac_consts.svh"
module mac_multiplier (
    // operands and their formats
    input wire logic [`MAC_DATA_W-1:0] x_data,
    input wire logic [`MAC_DATA_W-1:0] y_data,
    input wire logic x_signed,
    input wire logic y_signed,
    // product
    output logic [`MAC_PROD_W-1:0] product
);
    logic signed [`MAC_DATA_W:0] x_ext;
    logic signed [`MAC_DATA_W:0] y_ext;
    logic signed [2*`MAC_DATA_W+1:0] full;

    // one extra bit per operand carries the signed/unsigned choice
    assign x_ext = {x_signed & x_data[`MAC_DATA_W-1], x_data};
    assign y_ext = {y_signed & y_data[`MAC_DATA_W-1], y_data};
    assign full = x_ext * y_ext;
    assign product = full[`MAC_PROD_W-1:0];
endmodule
`default_nettype wire

/* File: rtl/mac_operand_file.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mac_consts.svh"
module mac_operand_file (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bank and read selects
    input wire logic bank,
    input wire logic op_sel,
    input wire logic bus_sel,
    // data memory bus write
    input wire logic dmd_we,
    input wire logic dmd_sel,
    input wire logic [`MAC_DATA_W-1:0] dmd_data,
    // program memory bus write
    input wire logic pmd_we,
    input wire logic pmd_sel,
    input wire logic [`MAC_DATA_W-1:0] pmd_data,
    // dual read ports
    output logic [`MAC_DATA_W-1:0] op_data,
    output logic [`MAC_DATA_W-1:0] bus_data
);
    logic [`MAC_DATA_W-1:0] regs [0:2*`MAC_BANKS-1];

    // entries are indexed {bank, register}; data bus wins a clash
    genvar i;
    generate
        for (i = 0; i < 2 * `MAC_BANKS; i++) begin : g_reg
            wire hit_d = dmd_we && ({bank, dmd_sel} == 2'(i));
            wire hit_p = pmd_we && ({bank, pmd_sel} == 2'(i));
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n)
                    regs[i] <= `MAC_REG_RST;
                else if (hit_d)
                    regs[i] <= dmd_data;
                else if (hit_p)
                    regs[i] <= pmd_data;
            end
        end
    endgenerate

    // two independent read ports on the stored values
    assign op_data = regs[{bank, op_sel}];
    assign bus_data = regs[{bank, bus_sel}];
endmodule
`default_nettype wire

/* File: rtl/mac_pkg.sv */
package mac_pkg;
    // multiply/accumulate operation of one instruction
    typedef enum logic [1:0] {
        mac_op_mult, mac_op_add, mac_op_sub, mac_op_clear
    } mac_op_t;
    // x operand source, register file or result bus
    typedef enum logic [2:0] {
        mac_xsrc_x0, mac_xsrc_x1, mac_xsrc_alu,
        mac_xsrc_acc_low, mac_xsrc_acc_mid, mac_xsrc_acc_ext
    } mac_xsrc_t;
    // y operand source
    typedef enum logic [1:0] {
        mac_ysrc_y0, mac_ysrc_y1, mac_ysrc_feedback
    } mac_ysrc_t;
    // register selected for a data-bus or result-bus access
    typedef enum logic [2:0] {
        mac_reg_acc_low, mac_reg_acc_mid, mac_reg_acc_ext,
        mac_reg_x0, mac_reg_x1, mac_reg_y0, mac_reg_y1,
        mac_reg_feedback
    } mac_reg_t;
endpackage

/* File: rtl/mac_unit.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mac_consts.svh"
module mac_unit
    import mac_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // mode status register from the sequencer
    input wire logic [`MAC_MODE_W-1:0] mode_status_register,
    // instruction for this cycle
    input wire logic op_valid,
    input wire mac_op_t op_code,
    input wire logic op_x_signed,
    input wire logic op_y_signed,
    input wire mac_xsrc_t op_x_src,
    input wire mac_ysrc_t op_y_src,
    input wire logic op_to_feedback,
    // alu result register on the result bus
    input wire logic [`MAC_DATA_W-1:0] alu_result_register,
    // data memory data bus
    input wire logic dmd_wr_en,
    input wire mac_reg_t dmd_wr_sel,
    input wire logic [`MAC_DATA_W-1:0] dmd_wr_data,
    input wire mac_reg_t dmd_rd_sel,
    output logic [`MAC_DATA_W-1:0] dmd_rd_data,
    // program memory data bus
    input wire logic pmd_wr_en,
    input wire logic pmd_wr_sel,
    input wire logic [`MAC_DATA_W-1:0] pmd_wr_data,
    // result bus driven by an accumulator section
    input wire mac_reg_t rbus_rd_sel,
    output logic [`MAC_DATA_W-1:0] rbus_rd_data,
    // overflow to the arithmetic status register
    output logic multiply_overflow_flag,
    output logic multiply_overflow_wr
);

    ////////////////////////////////////////////////////////////////////
    // helper functions

    // extension section as a 16-bit bus value
    function automatic logic [`MAC_DATA_W-1:0] ext_word(
        input logic [`MAC_EXT_W-1:0] e
    );
        ext_word = {{(`MAC_DATA_W-`MAC_EXT_W){e[`MAC_EXT_W-1]}}, e};
    endfunction

    // true for selections that target the x register file
    function automatic logic is_x_reg(input mac_reg_t r);
        is_x_reg = (r == mac_reg_x0) || (r == mac_reg_x1);
    endfunction

    // true for selections that target the y register file
    function automatic logic is_y_reg(input mac_reg_t r);
        is_y_reg = (r == mac_reg_y0) || (r == mac_reg_y1);
    endfunction

    // register file entry within x or y file
    function automatic logic file_index(input mac_reg_t r);
        file_index = (r == mac_reg_x1) || (r == mac_reg_y1);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // declarations

    // mode view
    logic bank;
    logic int_mode;

    // banked registers
    logic [`MAC_DATA_W-1:0] acc_low [0:`MAC_BANKS-1];
    logic [`MAC_DATA_W-1:0] acc_mid [0:`MAC_BANKS-1];
    logic [`MAC_EXT_W-1:0] acc_ext [0:`MAC_BANKS-1];
    logic [`MAC_DATA_W-1:0] feedback [0:`MAC_BANKS-1];

    // active bank view
    logic [`MAC_DATA_W-1:0] cur_low;
    logic [`MAC_DATA_W-1:0] cur_mid;
    logic [`MAC_EXT_W-1:0] cur_ext;
    logic [`MAC_DATA_W-1:0] cur_fb;
    logic [`MAC_ACC_W-1:0] cur_acc;

    // operand file ports
    logic [`MAC_DATA_W-1:0] x_file_op;
    logic [`MAC_DATA_W-1:0] x_file_bus;
    logic [`MAC_DATA_W-1:0] y_file_op;
    logic [`MAC_DATA_W-1:0] y_file_bus;

    // file selects and enables
    logic x_op_sel;
    logic y_op_sel;
    logic x_dmd_we;
    logic y_dmd_we;

    // selected operands
    logic [`MAC_DATA_W-1:0] x_operand;
    logic [`MAC_DATA_W-1:0] y_operand;

    // product path
    logic [`MAC_PROD_W-1:0] product;
    logic prod_ext;
    logic [`MAC_ACC_W-1:0] prod_aligned;

    // sum and overflow
    logic [`MAC_ACC_W-1:0] sum;
    logic [`MAC_MV_MSB-`MAC_MV_LSB:0] top_bits;
    logic next_mv;

    // write steering
    logic acc_wr;
    logic fb_wr;
    logic low_load;
    logic mid_load;
    logic ext_load;
    logic fb_load;

    // next register values
    logic [`MAC_DATA_W-1:0] next_low;
    logic [`MAC_DATA_W-1:0] next_mid;
    logic [`MAC_EXT_W-1:0] next_ext;
    logic [`MAC_DATA_W-1:0] next_fb;

    ////////////////////////////////////////////////////////////////////
    // mode bits and the active bank

    // both mode bits are sampled combinationally: same clock domain
    assign bank = mode_status_register[`MAC_MODE_BANK_BIT];
    assign int_mode = mode_status_register[`MAC_MODE_INT_BIT];

    // only the selected bank is visible anywhere
    assign cur_low = acc_low[bank];
    assign cur_mid = acc_mid[bank];
    assign cur_ext = acc_ext[bank];
    assign cur_fb = feedback[bank];
    assign cur_acc = {cur_ext, cur_mid, cur_low};

    ////////////////////////////////////////////////////////////////////
    // operand register files

    // register-file read selects and data-bus write enables
    assign x_op_sel = (op_x_src == mac_xsrc_x1);
    assign y_op_sel = (op_y_src == mac_ysrc_y1);
    // data-bus writes that land in a file
    assign x_dmd_we = dmd_wr_en && is_x_reg(dmd_wr_sel);
    assign y_dmd_we = dmd_wr_en && is_y_reg(dmd_wr_sel);

    // x file: data bus only; the program bus port is not wired here
    mac_operand_file u_x_file (
        .clk(clk),
        .rst_n(rst_n),
        .bank(bank),
        .op_sel(x_op_sel),
        .bus_sel(file_index(dmd_rd_sel)),
        .dmd_we(x_dmd_we),
        .dmd_sel(file_index(dmd_wr_sel)),
        .dmd_data(dmd_wr_data),
        .pmd_we(1'b0),
        .pmd_sel(1'b0),
        .pmd_data(`MAC_REG_RST),
        .op_data(x_file_op),
        .bus_data(x_file_bus)
    );

    // y file: written from the data bus or the program bus
    mac_operand_file u_y_file (
        .clk(clk),
        .rst_n(rst_n),
        .bank(bank),
        .op_sel(y_op_sel),
        .bus_sel(file_index(dmd_rd_sel)),
        .dmd_we(y_dmd_we),
        .dmd_sel(file_index(dmd_wr_sel)),
        .dmd_data(dmd_wr_data),
        .pmd_we(pmd_wr_en),
        .pmd_sel(pmd_wr_sel),
        .pmd_data(pmd_wr_data),
        .op_data(y_file_op),
        .bus_data(y_file_bus)
    );

    ////////////////////////////////////////////////////////////////////
    // operand selection

    // x from its file or any result-bus register
    always_comb begin
        unique case (op_x_src)
            mac_xsrc_x0,
            mac_xsrc_x1: x_operand = x_file_op;
            mac_xsrc_alu: x_operand = alu_result_register;
            mac_xsrc_acc_low: x_operand = cur_low;
            mac_xsrc_acc_mid: x_operand = cur_mid;
            mac_xsrc_acc_ext: x_operand = ext_word(cur_ext);
            default: x_operand = x_file_op;
        endcase
    end

    // y from its file or the feedback register of the last result
    always_comb begin
        unique case (op_y_src)
            mac_ysrc_y0,
            mac_ysrc_y1: y_operand = y_file_op;
            mac_ysrc_feedback: y_operand = cur_fb;
            default: y_operand = y_file_op;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // multiplier and product alignment

    // one multiplier serves the multiply, add and subtract operations
    mac_multiplier u_mult (
        .x_data(x_operand),
        .y_data(y_operand),
        .x_signed(op_x_signed),
        .y_signed(op_y_signed),
        .product(product)
    );

    // unsigned-by-unsigned products are zero-extended, others signed
    assign prod_ext = (op_x_signed | op_y_signed) & product[`MAC_PROD_W-1];

    // fractional drops the redundant sign bit: shift left, zero lsb
    assign prod_aligned = int_mode ?
        {{(`MAC_ACC_W-`MAC_PROD_W){prod_ext}}, product} :
        {{(`MAC_ACC_W-`MAC_PROD_W-1){prod_ext}}, product, 1'b0};

    ////////////////////////////////////////////////////////////////////
    // adder/subtractor

    // the 8 guard bits absorb intermediate overflow of a long sum
    always_comb begin
        unique case (op_code)
            mac_op_mult: sum = prod_aligned;
            mac_op_add: sum = cur_acc + prod_aligned;
            mac_op_sub: sum = cur_acc - prod_aligned;
            mac_op_clear: sum = `MAC_ACC_RST;
        endcase
    end

    // overflow: top nine bits neither all ones nor all zeros
    assign top_bits = sum[`MAC_MV_MSB:`MAC_MV_LSB];
    assign next_mv = ~(&top_bits) & (|top_bits);

    ////////////////////////////////////////////////////////////////////
    // write steering for the active bank

    // the result lands in the accumulator or in feedback
    assign acc_wr = op_valid && !op_to_feedback;
    assign fb_wr = op_valid && op_to_feedback;

    // a data-bus load of a section overrides the result in that section
    assign low_load = dmd_wr_en && (dmd_wr_sel == mac_reg_acc_low);
    assign mid_load = dmd_wr_en && (dmd_wr_sel == mac_reg_acc_mid);
    assign ext_load = dmd_wr_en && (dmd_wr_sel == mac_reg_acc_ext);
    assign fb_load = dmd_wr_en && (dmd_wr_sel == mac_reg_feedback);

    // low load touches no other section
    assign next_low = low_load ? dmd_wr_data :
        acc_wr ? sum[`MAC_DATA_W-1:0] : cur_low;

    // middle load also drives the extension fill
    assign next_mid = mid_load ? dmd_wr_data :
        acc_wr ? sum[2*`MAC_DATA_W-1:`MAC_DATA_W] : cur_mid;
    // an explicit extension load wins over the middle sign fill
    assign next_ext = ext_load ? dmd_wr_data[`MAC_EXT_W-1:0] :
        mid_load ? {`MAC_EXT_W{dmd_wr_data[`MAC_DATA_W-1]}} :
        acc_wr ? sum[`MAC_ACC_W-1:2*`MAC_DATA_W] : cur_ext;

    // feedback takes the data bus or result bits
    assign next_fb = fb_load ? dmd_wr_data :
        fb_wr ? sum[`MAC_FB_MSB:`MAC_FB_LSB] : cur_fb;

    ////////////////////////////////////////////////////////////////////
    // banked accumulator and feedback registers

    // only the selected bank updates; the other holds its context
    genvar b;
    generate
        for (b = 0; b < `MAC_BANKS; b++) begin : g_bank
            wire sel = (bank == 1'(b));
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    acc_low[b] <= `MAC_REG_RST;
                    acc_mid[b] <= `MAC_REG_RST;
                    acc_ext[b] <= `MAC_EXT_RST;
                    feedback[b] <= `MAC_REG_RST;
                end else if (sel) begin
                    acc_low[b] <= next_low;
                    acc_mid[b] <= next_mid;
                    acc_ext[b] <= next_ext;
                    feedback[b] <= next_fb;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // overflow status toward the arithmetic status register

    // held flag plus a one-cycle strobe telling status to take it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            multiply_overflow_flag <= 1'b0;
            multiply_overflow_wr <= 1'b0;
        end else begin
            multiply_overflow_wr <= op_valid;
            if (op_valid)
                multiply_overflow_flag <= next_mv;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read ports

    // the data bus reads stored values, so a same-cycle write is
    // seen only on the next cycle
    always_comb begin
        unique case (dmd_rd_sel)
            mac_reg_acc_low: dmd_rd_data = cur_low;
            mac_reg_acc_mid: dmd_rd_data = cur_mid;
            mac_reg_acc_ext: dmd_rd_data = ext_word(cur_ext);
            mac_reg_x0,
            mac_reg_x1: dmd_rd_data = x_file_bus;
            mac_reg_y0,
            mac_reg_y1: dmd_rd_data = y_file_bus;
            mac_reg_feedback: dmd_rd_data = cur_fb;
        endcase
    end

    // only accumulator sections sit on the result bus; others read 0
    always_comb begin
        unique case (rbus_rd_sel)
            mac_reg_acc_low: rbus_rd_data = cur_low;
            mac_reg_acc_mid: rbus_rd_data = cur_mid;
            mac_reg_acc_ext: rbus_rd_data = ext_word(cur_ext);
            default: rbus_rd_data = `MAC_REG_RST;
        endcase
    end

endmodule
`default_nettype wire
